//--- core/tws_bus_mon.sv
`timescale 1ns/100ps
// Finds clock edges and start/stop conditions on synchronised lines
module tws_bus_mon (
  input wire logic clk,
  input wire logic rst_n,
  tws_line_if.mon  line
);

  logic scl_prev_reg; // Clock one sample ago
  logic sda_prev_reg; // Data one sample ago

  // ------------------------------------------------------------------
  // Previous samples
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= line.scl;
      sda_prev_reg <= line.sda;
    end
  end

  // Edge and condition decode
  assign line.scl_rise  = line.scl & ~scl_prev_reg;
  assign line.scl_fall  = ~line.scl & scl_prev_reg;
  assign line.start_det = line.scl & scl_prev_reg & sda_prev_reg
                          & ~line.sda;
  assign line.stop_det  = line.scl & scl_prev_reg & ~sda_prev_reg
                          & line.sda;

endmodule

//--- core/tws_line_if.sv
`timescale 1ns/100ps
// Synchronised bus lines and the events found on them
interface tws_line_if;
  logic scl;       // Synchronised clock line
  logic sda;       // Synchronised data line
  logic scl_rise;  // Clock rose
  logic scl_fall;  // Clock fell
  logic start_det; // Data fell while clock high
  logic stop_det;  // Data rose while clock high

  modport mon  (input scl, sda,
                output scl_rise, scl_fall, start_det, stop_det);
  modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

//--- core/tws_pkg.sv
package tws_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_BYTE_BUFFER = 8'h9a; // Serial byte buffer
  localparam logic [7:0] ADDR_OWN_ADDRESS = 8'h9b; // Own bus address
  localparam logic [7:0] ADDR_CONTROL     = 8'he8; // Two-wire control

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE_BUFFER  = 8'h00;
  localparam logic [7:0] RST_OWN_ADDRESS  = 8'h55;
  localparam logic [7:0] RST_CONTROL      = 8'h00;

  // ------------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------------
  localparam int BIT_MDATA_OUT  = 7; // Software master data out
  localparam int BIT_MDATA_EN   = 6; // Software master data drive enable
  localparam int BIT_MCLK_OUT   = 5; // Software master clock out
  localparam int BIT_MDATA_IN   = 4; // Software master data in
  localparam int BIT_MODE_SEL   = 3; // 1 = software master, 0 = slave
  localparam int BIT_IF_RESET   = 2; // Slave interface reset
  localparam int BIT_DIRECTION  = 1; // Slave transmitting
  localparam int BIT_BYTE_DONE  = 0; // Byte transferred

  // ------------------------------------------------------------------
  // Byte framing
  // ------------------------------------------------------------------
  localparam logic [3:0] LAST_BIT_IDX = 4'h7; // Eighth bit of a byte

  // Slave engine states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_ACK   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110,
    ST_SKIP     = 3'b111
  } tws_state_type;

endpackage

//--- core/tws_port.sv
// Behaviour
// - Master mode drives data bit when enabled
// - Drive enable makes data pin output, else input
// - Master mode drives clock bit onto clock
// - Master mode latches data pin into input bit on clock rise while not driving
// - Mode bit: set master, clear slave
// - Interface reset bit holds slave engine idle
// - Direction bit set transmitting, clear receiving
// - Byte done flag set per data byte, not for the address byte
// - Buffer access clears flag and request
// - Buffer write transmits, read returns received byte
// - Own address register resets default, always writable
// - Peripheral select releases pins to other port
`timescale 1ns/100ps
module tws_port (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       SERIAL_PERIPHERAL_SELECT,
  input  wire logic       SERIAL_DATA_PIN_I,
  output logic            SERIAL_DATA_PIN_O,
  output logic            SERIAL_DATA_PIN_OE,
  input  wire logic       SERIAL_CLOCK_PIN_I,
  output logic            SERIAL_CLOCK_PIN_O,
  output logic            SERIAL_CLOCK_PIN_OE,
  output logic            BYTE_IRQ
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  tws_line_if line ();                     // Synchronised line events

  logic [1:0] pins_sync;                   // {clock, data} synchronised
  logic       spi_sel_reg;                 // Peripheral select, stage 1
  logic       spi_sel_sync_reg;            // Peripheral select, stage 2

  // Registers
  logic [7:0] serial_byte_buffer_reg;      // Data register
  logic [7:0] serial_byte_buffer_next;
  logic [7:0] own_bus_address_reg;         // Own address register
  logic       sw_master_data_out_reg;      // Master data out bit
  logic       sw_master_data_drive_en_reg; // Master drive enable bit
  logic       sw_master_clock_out_reg;     // Master clock out bit
  logic       sw_master_data_in_reg;       // Master data in bit
  logic       sw_master_data_in_next;
  logic       master_slave_select_reg;     // Mode bit
  logic       interface_reset_ctl_reg;     // Slave reset bit
  logic       transfer_direction_flag_reg; // Slave direction bit
  logic       transfer_direction_flag_next;
  logic       byte_done_flag_reg;          // Byte done flag
  logic       byte_done_flag_next;
  logic [7:0] rdata_reg;                   // Read data
  logic [7:0] rdata_next;

  // Slave engine
  tws_pkg::tws_state_type st_reg;          // Engine state
  tws_pkg::tws_state_type st_next;
  logic [3:0] cnt_reg;                     // Bit counter
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;                      // Shift register
  logic [7:0] sh_next;
  logic       drv_reg;                     // Pull data line low
  logic       drv_next;
  logic [1:0] ph_reg;                      // Acknowledge phase
  logic [1:0] ph_next;
  logic       byte_evt;                    // Byte finished this cycle
  logic       rx_load;                     // Received byte to buffer
  logic [7:0] rx_byte;                     // Byte being completed

  // Pin drivers
  logic sda_o_reg, sda_oe_reg, scl_o_reg, scl_oe_reg;
  logic sda_o_next, sda_oe_next, scl_o_next, scl_oe_next;

  // ------------------------------------------------------------------
  // Synchronisers and line monitor
  // ------------------------------------------------------------------
  tws_sync #(.WIDTH(2)) u_sync (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .async_in ({SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I}),
    .sync_out (pins_sync)
  );
  assign line.scl = pins_sync[1];
  assign line.sda = pins_sync[0];

  tws_bus_mon u_mon (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .line  (line)
  );

  // Select comes from another block's register; kept as a pin input
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      spi_sel_reg      <= 1'b0;
      spi_sel_sync_reg <= 1'b0;
    end else begin
      spi_sel_reg      <= SERIAL_PERIPHERAL_SELECT;
      spi_sel_sync_reg <= spi_sel_reg;
    end
  end

  // ------------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------------
  wire hit_buf   = SFR_ADDR == tws_pkg::ADDR_BYTE_BUFFER;
  wire hit_own   = SFR_ADDR == tws_pkg::ADDR_OWN_ADDRESS;
  wire hit_ctl   = SFR_ADDR == tws_pkg::ADDR_CONTROL;
  wire buf_touch = hit_buf & (SFR_RD | SFR_WR);
  wire wr_buf    = hit_buf & SFR_WR;
  wire wr_own    = hit_own & SFR_WR;
  wire wr_ctl    = hit_ctl & SFR_WR;

  wire master_mode = master_slave_select_reg;
  wire two_wire_on = ~spi_sel_sync_reg;
  wire slave_hold  = master_mode | interface_reset_ctl_reg
                     | ~two_wire_on;

  wire [7:0] ctl_view = {sw_master_data_out_reg,
                         sw_master_data_drive_en_reg,
                         sw_master_clock_out_reg,
                         sw_master_data_in_reg,
                         master_slave_select_reg,
                         interface_reset_ctl_reg,
                         transfer_direction_flag_reg,
                         byte_done_flag_reg};

  // Read mux, unmapped addresses return zero
  assign rdata_next = !SFR_RD ? 8'h00 :
                      hit_buf ? serial_byte_buffer_reg :
                      hit_own ? own_bus_address_reg :
                      hit_ctl ? ctl_view : 8'h00;

  // Hardware event wins over the clearing access
  assign byte_done_flag_next = byte_evt ? 1'b1 :
                               buf_touch ? 1'b0 :
                               byte_done_flag_reg;

  // Received byte wins over a software write in the same cycle
  assign serial_byte_buffer_next = rx_load ? rx_byte :
                                   wr_buf ? SFR_WDATA :
                                   serial_byte_buffer_reg;

  // Data pin sampled on clock rise while not driving
  assign sw_master_data_in_next =
    (master_mode & two_wire_on & ~sw_master_data_drive_en_reg
     & line.scl_rise) ? line.sda : sw_master_data_in_reg;

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      serial_byte_buffer_reg <= tws_pkg::RST_BYTE_BUFFER;
      own_bus_address_reg    <= tws_pkg::RST_OWN_ADDRESS;
      rdata_reg              <= 8'h00;
      byte_done_flag_reg     <= 1'b0;
      sw_master_data_in_reg  <= 1'b0;
    end else begin
      serial_byte_buffer_reg <= serial_byte_buffer_next;
      if (wr_own) begin
        own_bus_address_reg <= SFR_WDATA;
      end
      rdata_reg              <= rdata_next;
      byte_done_flag_reg     <= byte_done_flag_next;
      sw_master_data_in_reg  <= sw_master_data_in_next;
    end
  end

  // Software-written control bits
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      {sw_master_data_out_reg, sw_master_data_drive_en_reg,
       sw_master_clock_out_reg} <= tws_pkg::RST_CONTROL[7:5];
      master_slave_select_reg   <= tws_pkg::RST_CONTROL[3];
      interface_reset_ctl_reg   <= tws_pkg::RST_CONTROL[2];
    end else if (wr_ctl) begin
      sw_master_data_out_reg      <= SFR_WDATA[tws_pkg::BIT_MDATA_OUT];
      sw_master_data_drive_en_reg <= SFR_WDATA[tws_pkg::BIT_MDATA_EN];
      sw_master_clock_out_reg     <= SFR_WDATA[tws_pkg::BIT_MCLK_OUT];
      master_slave_select_reg     <= SFR_WDATA[tws_pkg::BIT_MODE_SEL];
      interface_reset_ctl_reg     <= SFR_WDATA[tws_pkg::BIT_IF_RESET];
    end
  end

  // ------------------------------------------------------------------
  // Slave engine next state
  // ------------------------------------------------------------------
  assign rx_byte = {sh_reg[6:0], line.sda};
  wire   addr_match = sh_reg[7:1] == own_bus_address_reg[6:0];
  wire   last_bit   = cnt_reg == tws_pkg::LAST_BIT_IDX;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    drv_next = drv_reg;
    ph_next  = ph_reg;
    byte_evt = 1'b0;
    rx_load  = 1'b0;
    transfer_direction_flag_next = transfer_direction_flag_reg;
    if (slave_hold) begin
      // Held idle, line released
      st_next  = tws_pkg::ST_IDLE;
      drv_next = 1'b0;
      if (interface_reset_ctl_reg) begin
        transfer_direction_flag_next = 1'b0;
      end
    end else if (line.stop_det) begin
      st_next  = tws_pkg::ST_IDLE;
      drv_next = 1'b0;
    end else if (line.start_det) begin
      // Start or repeated start: collect the address
      st_next  = tws_pkg::ST_ADDR;
      cnt_next = 4'h0;
      drv_next = 1'b0;
    end else begin
      unique case (st_reg)
        tws_pkg::ST_IDLE: begin
          drv_next = 1'b0;
        end
        tws_pkg::ST_ADDR: begin
          if (line.scl_rise) begin
            sh_next  = rx_byte;
            cnt_next = cnt_reg + 4'h1;
            if (last_bit) begin
              st_next = tws_pkg::ST_ADDR_ACK;
              ph_next = 2'd0;
            end
          end
        end
        tws_pkg::ST_ADDR_ACK: begin
          if (line.scl_fall && ph_reg == 2'd0) begin
            if (addr_match) begin
              drv_next = 1'b1;
              ph_next  = 2'd1;
              transfer_direction_flag_next = sh_reg[0];
            end else begin
              st_next = tws_pkg::ST_SKIP;
            end
          end else if (line.scl_fall) begin
            cnt_next = 4'h0;
            if (sh_reg[0]) begin
              // Read: first bit of buffer goes out now
              st_next  = tws_pkg::ST_TX;
              sh_next  = serial_byte_buffer_reg;
              drv_next = ~serial_byte_buffer_reg[7];
            end else begin
              st_next  = tws_pkg::ST_RX;
              drv_next = 1'b0;
            end
          end
        end
        tws_pkg::ST_RX: begin
          if (line.scl_rise) begin
            sh_next  = rx_byte;
            cnt_next = cnt_reg + 4'h1;
            if (last_bit) begin
              rx_load  = 1'b1;
              byte_evt = 1'b1;
              st_next  = tws_pkg::ST_RX_ACK;
              ph_next  = 2'd0;
            end
          end
        end
        tws_pkg::ST_RX_ACK: begin
          if (line.scl_fall && ph_reg == 2'd0) begin
            drv_next = 1'b1;
            ph_next  = 2'd1;
          end else if (line.scl_fall) begin
            drv_next = 1'b0;
            cnt_next = 4'h0;
            st_next  = tws_pkg::ST_RX;
          end
        end
        tws_pkg::ST_TX: begin
          if (line.scl_fall) begin
            sh_next  = {sh_reg[6:0], 1'b0};
            drv_next = ~sh_reg[6];
          end else if (line.scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
            if (last_bit) begin
              byte_evt = 1'b1;
              st_next  = tws_pkg::ST_TX_ACK;
              ph_next  = 2'd0;
            end
          end
        end
        tws_pkg::ST_TX_ACK: begin
          if (line.scl_fall && ph_reg == 2'd0) begin
            drv_next = 1'b0;
            ph_next  = 2'd1;
          end else if (line.scl_rise && ph_reg == 2'd1) begin
            // Master acknowledge keeps the read going
            if (line.sda) begin
              st_next = tws_pkg::ST_SKIP;
            end else begin
              ph_next = 2'd2;
            end
          end else if (line.scl_fall && ph_reg == 2'd2) begin
            st_next  = tws_pkg::ST_TX;
            cnt_next = 4'h0;
            sh_next  = serial_byte_buffer_reg;
            drv_next = ~serial_byte_buffer_reg[7];
          end
        end
        tws_pkg::ST_SKIP: begin
          drv_next = 1'b0;
        end
      endcase
    end
  end

  // Slave engine state
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_reg  <= tws_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg  <= 8'h00;
      drv_reg <= 1'b0;
      ph_reg  <= 2'd0;
      transfer_direction_flag_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      sh_reg  <= sh_next;
      drv_reg <= drv_next;
      ph_reg  <= ph_next;
      transfer_direction_flag_reg <= transfer_direction_flag_next;
    end
  end

  // ------------------------------------------------------------------
  // Pin drive selection
  // ------------------------------------------------------------------
  assign sda_oe_next = ~two_wire_on ? 1'b0 :
                       master_mode ? sw_master_data_drive_en_reg :
                       drv_reg;
  assign sda_o_next  = two_wire_on & master_mode
                       & sw_master_data_out_reg;
  assign scl_oe_next = two_wire_on & master_mode;
  assign scl_o_next  = two_wire_on & master_mode
                       & sw_master_clock_out_reg;

  // Output flip-flops
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sda_o_reg  <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_o_reg  <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else begin
      sda_o_reg  <= sda_o_next;
      sda_oe_reg <= sda_oe_next;
      scl_o_reg  <= scl_o_next;
      scl_oe_reg <= scl_oe_next;
    end
  end

  assign SERIAL_DATA_PIN_O   = sda_o_reg;
  assign SERIAL_DATA_PIN_OE  = sda_oe_reg;
  assign SERIAL_CLOCK_PIN_O  = scl_o_reg;
  assign SERIAL_CLOCK_PIN_OE = scl_oe_reg;
  assign SFR_RDATA           = rdata_reg;
  assign BYTE_IRQ            = byte_done_flag_reg;

endmodule

//--- core/tws_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser, one per bit
module tws_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ------------------------------------------------------------------
  // Per-bit flip-flop pair
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg; // First stage, read only by the second
      logic hold_reg; // Second stage
      // Lines idle high on the bus
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_reg <= 1'b1;
          hold_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          hold_reg <= meta_reg;
        end
      end
      assign sync_out[i] = hold_reg;
    end
  endgenerate

endmodule

//--- tb/test_tws_port.sv
`timescale 1ns/100ps
module test_tws_port;
  logic       sys_clk = 1'b0; // Core clock
  logic       rst_n = 1'b0;   // Reset, active low
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       sel = 1'b0;     // Pins given to the other port
  logic       sda_o, sda_oe, scl_o, scl_oe, byte_irq, m_scl, m_sda;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cyc = 0;
  // Wired-and lines with pull-ups
  wire sda_line = m_sda & ~(sda_oe & ~sda_o);
  wire scl_line = m_scl & ~(scl_oe & ~scl_o);
  always #25 sys_clk = ~sys_clk;
  tws_port dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata),
    .SFR_RDATA(sfr_rdata), .SERIAL_PERIPHERAL_SELECT(sel),
    .SERIAL_DATA_PIN_I(sda_line), .SERIAL_DATA_PIN_O(sda_o),
    .SERIAL_DATA_PIN_OE(sda_oe), .SERIAL_CLOCK_PIN_I(scl_line),
    .SERIAL_CLOCK_PIN_O(scl_o), .SERIAL_CLOCK_PIN_OE(scl_oe),
    .BYTE_IRQ(byte_irq));
  tws_master_model mst (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_line));
  // ----------------------------------------
  // Register access and checking
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  // Read data stands one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    wr(8'h9c, 8'hff); // Unmapped write is dropped
    rd(8'h9a, v);
    chk(v, 8'h00);
    rd(8'h9b, v);
    chk(v, 8'h55);
    rd(8'h9c, v);
    chk(v, 8'h00);
    $display("Test reset values done");
  endtask
  task automatic t_master();
    logic [7:0] v;
    wr(8'he8, 8'hff);
    repeat (4) @(negedge sys_clk);
    chk({4'h0, sda_o, sda_oe, scl_o, scl_oe}, 8'h0f);
    rd(8'he8, v);
    chk(v, 8'hec);
    wr(8'he8, 8'h48);
    repeat (4) @(negedge sys_clk);
    chk({4'h0, sda_o, sda_oe, scl_o, scl_oe}, 8'h05);
    for (int i = 0; i < 2; i++) begin
      mst.sda_o = ~i[0];
      wr(8'he8, 8'h08);
      repeat (4) @(negedge sys_clk);
      wr(8'he8, 8'h28);
      repeat (8) @(negedge sys_clk);
      rd(8'he8, v);
      chk(v, {3'b001, ~i[0], 4'h8});
    end
    chk({7'h0, sda_oe}, 8'h00);
    mst.sda_o = 1'b1;
    wr(8'he8, 8'h00);
    $display("Test software master done");
  endtask
  task automatic t_slave();
    logic [7:0] v, q;
    logic n;
    wr(8'h9b, 8'h3c);
    rd(8'h9b, v);
    chk(v, 8'h3c);
    mst.start();
    mst.xfer(8'h78, 1'b1, q, n);
    chk({7'h0, n}, 8'h00);
    mst.xfer(8'ha5, 1'b1, q, n);
    chk({6'h0, n, byte_irq}, 8'h01);
    rd(8'he8, v);
    chk(v, 8'h01);
    rd(8'h9a, v); // One buffer access per byte
    chk(v, 8'ha5);
    @(negedge sys_clk);
    chk({7'h0, byte_irq}, 8'h00);
    mst.stop();
    wr(8'h9a, 8'h96);
    mst.start();
    mst.xfer(8'h79, 1'b1, q, n);
    rd(8'he8, v);
    chk(v, {7'h01, n});
    mst.xfer(8'hff, 1'b1, q, n);
    chk(q, 8'h96);
    rd(8'he8, v);
    chk(v, 8'h03);
    mst.stop();
    rd(8'h9a, v); // One buffer access per byte
    @(negedge sys_clk);
    chk({7'h0, byte_irq}, 8'h00);
    $display("Test slave transfers done");
  endtask
  // Held interface, pins given away, or a foreign address: no answer
  task automatic t_refuse(input logic s, input logic [7:0] c,
                          input logic [6:0] a);
    logic [7:0] v, q;
    logic n;
    wr(8'he8, c);
    sel = s;
    repeat (8) @(negedge sys_clk);
    chk({6'h0, sda_oe, scl_oe}, 8'h00);
    mst.start();
    mst.xfer({a, 1'b0}, 1'b1, q, n);
    mst.stop();
    chk({7'h0, n}, 8'h01);
    rd(8'he8, v);
    chk(v, c);
    sel = 1'b0;
    wr(8'he8, 8'h00);
    $display("Test refusal done");
  endtask
  // Ceiling well above the fewer than a thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_master();
    t_slave();
    t_refuse(1'b0, 8'h04, 7'h3c);
    t_refuse(1'b1, 8'h00, 7'h3c);
    t_refuse(1'b0, 8'h00, 7'h20);
    stop_test();
  end
endmodule
bind tws_port tws_port_assertions chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
  .SERIAL_PERIPHERAL_SELECT(SERIAL_PERIPHERAL_SELECT),
  .SERIAL_CLOCK_PIN_I(SERIAL_CLOCK_PIN_I),
  .SERIAL_DATA_PIN_O(SERIAL_DATA_PIN_O),
  .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE),
  .SERIAL_CLOCK_PIN_O(SERIAL_CLOCK_PIN_O),
  .SERIAL_CLOCK_PIN_OE(SERIAL_CLOCK_PIN_OE), .BYTE_IRQ(BYTE_IRQ));

//--- tb/tws_master_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// External bus master, open drain, 400 ns bit time
// ----------------------------------------
module tws_master_model (
  output logic      scl_o, // Clock drive, 1 = released
  output logic      sda_o, // Data drive, 1 = released
  input  wire logic sda_i  // Resolved data line
);
  // Idle bus: both released, clock stands still
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data falls while clock high, then clock drops
  task automatic start();
    sda_o = 1'b0;
    #200;
    scl_o = 1'b0;
  endtask
  // One bit: data moves while clock low, line sampled late in high
  task automatic bit_io(input logic b, output logic s);
    #50;
    sda_o = b;
    #150;
    scl_o = 1'b1;
    #200;
    s = sda_i;
    scl_o = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ak, nak);
  endtask
  // Data rises while clock high
  task automatic stop();
    #50;
    sda_o = 1'b0;
    #150;
    scl_o = 1'b1;
    #200;
    sda_o = 1'b1;
    #200;
  endtask
endmodule

//--- tb/tws_port_assertions.sv
`timescale 1ns/100ps
module tws_port_assertions (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       SERIAL_PERIPHERAL_SELECT,
  input wire logic       SERIAL_CLOCK_PIN_I,
  input wire logic       SERIAL_DATA_PIN_O,
  input wire logic       SERIAL_DATA_PIN_OE,
  input wire logic       SERIAL_CLOCK_PIN_O,
  input wire logic       SERIAL_CLOCK_PIN_OE,
  input wire logic       BYTE_IRQ
);
  // ----------------------------------------
  // Mirrors of software writes and line quiet
  // ----------------------------------------
  logic [7:0] ctl_q;    // Last control write
  logic [7:0] own_q;    // Last own address write
  logic [2:0] settle_q; // Cycles since control or select moved
  logic [3:0] quiet_q;  // Cycles since the clock pin moved
  logic       sel_q;    // Previous select level
  logic       scl_q;    // Previous clock pin level
  wire ctl_wr  = SFR_WR && SFR_ADDR == 8'he8;
  wire buf_acc = (SFR_WR || SFR_RD) && SFR_ADDR == 8'h9a;
  wire settled = settle_q == 3'h7;
  wire master  = ctl_q[3] && !SERIAL_PERIPHERAL_SELECT && settled;
  // Track writes; settle waits out the synchroniser and output flops
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctl_q    <= 8'h00;
      own_q    <= 8'h55;
      settle_q <= 3'h0;
      quiet_q  <= 4'h0;
      sel_q    <= 1'b0;
      scl_q    <= 1'b1;
    end else begin
      ctl_q    <= ctl_wr ? SFR_WDATA : ctl_q;
      own_q    <= (SFR_WR && SFR_ADDR == 8'h9b) ? SFR_WDATA : own_q;
      settle_q <= (ctl_wr || sel_q != SERIAL_PERIPHERAL_SELECT) ? 3'h0 :
                  settled ? settle_q : settle_q + 3'h1;
      quiet_q  <= (scl_q != SERIAL_CLOCK_PIN_I) ? 4'h0 :
                  (&quiet_q) ? quiet_q : quiet_q + 4'h1;
      sel_q    <= SERIAL_PERIPHERAL_SELECT;
      scl_q    <= SERIAL_CLOCK_PIN_I;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  chk_rdata_idle: assert property (
    !$past(SFR_RD) |-> SFR_RDATA == 8'h00) else $error("read data not idle");
  chk_own_readback: assert property (
    SFR_RD && !SFR_WR && SFR_ADDR == 8'h9b |=> SFR_RDATA == $past(own_q))
    else $error("own address read back wrong");
  chk_flag_clear: assert property (
    buf_acc && !scl_q && quiet_q != 4'h0 |=> !BYTE_IRQ)
    else $error("flag not cleared");
  chk_flag_slave: assert property (
    $rose(BYTE_IRQ) |-> !ctl_q[3] && !ctl_q[2]) else $error("flag in wrong mode");
  chk_master_clock: assert property (
    master |-> SERIAL_CLOCK_PIN_OE && SERIAL_CLOCK_PIN_O == ctl_q[5])
    else $error("clock pin not following control");
  chk_master_enable: assert property (
    master |-> SERIAL_DATA_PIN_OE == ctl_q[6]) else $error("data enable wrong");
  chk_master_data: assert property (
    master && ctl_q[6] |-> SERIAL_DATA_PIN_O == ctl_q[7])
    else $error("data pin not following control");
  chk_select_release: assert property (
    SERIAL_PERIPHERAL_SELECT && settled |->
    !SERIAL_CLOCK_PIN_OE && !SERIAL_DATA_PIN_OE) else $error("pins not released");
  chk_slave_clock: assert property (
    !ctl_q[3] && settled |-> !SERIAL_CLOCK_PIN_OE) else $error("slave drives clock");
  chk_iface_reset: assert property (
    !ctl_q[3] && ctl_q[2] && settled |-> !SERIAL_DATA_PIN_OE [*4])
    else $error("held interface drives data");
  cover property ($rose(BYTE_IRQ));
  cover property (master && SERIAL_DATA_PIN_OE);
  cover property (SERIAL_PERIPHERAL_SELECT && settled);
endmodule
